//--- bcr_pkg.sv
package bcr_pkg;
    // Configuration offsets (byte addresses within the function's space)
    localparam logic [7:0]  BCR_DEVICE_IDENTIFIER_OFF = 8'h02;
    localparam logic [7:0]  BCR_BRIDGE_COMMAND_OFF    = 8'h04;
    // Dword-aligned addresses, one per register
    localparam logic [7:0]  BCR_DWORD0_OFF            = 8'h00;
    localparam logic [7:0]  BCR_DWORD1_OFF            = 8'h04;
    // Command field positions
    localparam int          BCR_PARITY_ERROR_REPORT_ENABLE_BIT   = 6;
    localparam int          BCR_SYSTEM_ERROR_MESSAGE_ENABLE_BIT  = 8;
    localparam int          BCR_INTERRUPT_ASSERTION_DISABLE_BIT  = 10;
    // Writable mask of command bits 15:5 covered here
    localparam logic [15:0] BCR_COMMAND_WRITE_MASK    = 16'h0540;
    // Reset value of the command register
    localparam logic [15:0] BCR_COMMAND_RESET         = 16'h0000;
    // Device identifier; value is arbitrary
    localparam logic [15:0] BCR_DEVICE_IDENTIFIER     = 16'h5a5a;
    // Interrupt message kinds
    typedef enum logic [1:0] {
        BCR_MSG_NONE,
        BCR_MSG_ASSERT,
        BCR_MSG_DEASSERT
    } bcr_msg_t;
endpackage : bcr_pkg

//--- bcr_cmd_bit.sv
`timescale 1ns/1ns
// One writable command bit with byte-lane write enable
module bcr_cmd_bit (
    // Clock and reset
    input  wire logic clock_in,
    input  wire logic srst_in,
    // Write path
    input  wire logic wr_en_in,
    input  wire logic wr_data_in,
    // Stored value
    output logic      bit_out
);
    import bcr_pkg::*;

    logic bit_reg;   // Stored command bit
    logic bit_next;  // Next value

    // Clear on reset, else update only on an enabled write
    always_comb begin
        bit_next = bit_reg;
        if (srst_in) begin
            bit_next = 1'b0;
        end else if (wr_en_in) begin
            bit_next = wr_data_in;
        end
    end

    // Register only
    always_ff @(posedge clock_in) begin
        bit_reg <= bit_next;
    end

    assign bit_out = bit_reg;
endmodule : bcr_cmd_bit

//--- bcr_bridge_command.sv
`timescale 1ns/1ns
// Overview of operation
// RL1 - Device identifier reads fixed at offset 2
// RL2 - Bits 15:11, 9, 7, 5 read zero
// RL3 - Clear disable bit permits own INTA messages
// RL4 - Set disable stops own messages, deasserts pending INTA
// RL5 - Disable gates only own PME/hot-plug interrupts
// RL6 - SERR enable sends primary-side errors only
// RL7 - Report if SERR enable or device control
// RL8 - Command-enabled SERR recorded in primary status
// RL9 - Bit 6 gates master parity error flag
// RL10 - Writable bits reset zero, byte-enabled writes
module bcr_bridge_command (
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        srst_in,
    // Configuration access (dword address, byte enables)
    input  wire logic        cfg_rd_in,
    input  wire logic        cfg_wr_in,
    input  wire logic [7:0]  cfg_addr_in,
    input  wire logic [3:0]  cfg_be_in,
    input  wire logic [31:0] cfg_wdata_in,
    output logic [31:0]      cfg_rdata_out,
    output logic             cfg_rvalid_out,
    // Own interrupt source (PME or hot plug), level
    input  wire logic        own_intr_in,
    // Forwarded upstream interrupt messages, one-cycle
    input  wire logic        fwd_msg_valid_in,
    input  wire bcr_pkg::bcr_msg_t fwd_msg_kind_in,
    // Outgoing INTA message, one-cycle
    output logic             inta_msg_valid_out,
    output bcr_pkg::bcr_msg_t inta_msg_kind_out,
    // Error detection, one-cycle pulses; device control enable is a level
    input  wire logic        primary_err_in,
    input  wire logic        secondary_err_in,
    input  wire logic        devctl_err_en_in,
    input  wire logic        master_parity_err_in,
    // SERR message and status events, one-cycle
    output logic             serr_msg_out,
    output logic             serr_status_set_out,
    output logic             parity_status_set_out,
    // Command enables to the rest of the bridge
    output logic             system_error_message_enable_out,
    output logic             parity_error_report_enable_out,
    output logic             interrupt_assertion_disable_out
);
    import bcr_pkg::*;
    // Package holds every offset, mask and message kind

    // Command register image
    logic [15:0] command;          // Assembled command value
    // Write lane decode
    logic        wr_cmd_lo;        // Write to byte 0 of command
    logic        wr_cmd_hi;        // Write to byte 1 of command
    // Read answer state
    logic [31:0] rdata_next;       // Read data next
    logic [31:0] rdata_reg;        // Registered read data
    logic        rvalid_next;      // Read answer next
    logic        rvalid_reg;       // Read answer
    // Interrupt message state
    logic        intr_sent_reg;    // INTA currently asserted at far end
    logic        intr_sent_next;   // Next far-end INTA level
    logic        msg_valid_reg;    // Outgoing message strobe
    logic        msg_valid_next;   // Next message strobe
    bcr_msg_t    msg_kind_reg;     // Outgoing message kind
    bcr_msg_t    msg_kind_next;    // Next message kind
    // Error event state
    logic        serr_reg;         // SERR message pulse
    logic        serr_next;        // Next SERR message pulse
    logic        serr_stat_reg;    // Primary status event pulse
    logic        serr_stat_next;   // Next status event pulse
    logic        par_reg;          // Parity status event pulse
    logic        par_next;         // Next parity event pulse

    // Address match, used by read and write decode
    // Only bits 7:2 count, so any byte offset inside a dword selects it
    // Kept as a function because read and write decode both use it
    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
        addr_hit = (a[7:2] == off[7:2]);
    endfunction : addr_hit

    // Command bits 15:0 sit in lanes 0 and 1 of dword 1
    // Lane 0 carries bit 6; lane 1 carries bits 10 and 8
    // A write with neither lane enabled changes nothing
    assign wr_cmd_lo = cfg_wr_in && addr_hit(cfg_addr_in, BCR_DWORD1_OFF) && cfg_be_in[0]; // RL10
    assign wr_cmd_hi = cfg_wr_in && addr_hit(cfg_addr_in, BCR_DWORD1_OFF) && cfg_be_in[1]; // RL10

    // Only writable positions get a flop; the rest stay zero
    // Hardwired bits get no flop, so no write can ever set them
    // Per-bit cells cost some wiring but keep every enable simple
    // Walk the covered positions 15:5
    genvar gi;
    generate
        for (gi = 5; gi < 16; gi++) begin : g_cmd
            if (BCR_COMMAND_WRITE_MASK[gi]) begin : g_rw
                // Bits below 8 sit in lane 0, the rest in lane 1
                bcr_cmd_bit u_bit (
                    .clock_in   (clock_in),
                    .srst_in    (srst_in),
                    .wr_en_in   ((gi < 8) ? wr_cmd_lo : wr_cmd_hi),
                    .wr_data_in (cfg_wdata_in[gi]),
                    .bit_out    (command[gi])
                ); // RL10
            end else begin : g_ro
                assign command[gi] = 1'b0; // RL2
            end
        end
    endgenerate
    // Bits 4:0 are handled elsewhere in the bridge; read zero here
    // Keeps the read image a full 16 bits wide
    assign command[4:0] = 5'h00;

    // Enables straight from the command flops
    // Levels, held until software rewrites them
    assign interrupt_assertion_disable_out = command[BCR_INTERRUPT_ASSERTION_DISABLE_BIT];
    assign system_error_message_enable_out = command[BCR_SYSTEM_ERROR_MESSAGE_ENABLE_BIT];
    assign parity_error_report_enable_out  = command[BCR_PARITY_ERROR_REPORT_ENABLE_BIT];

    // Read decode; unmapped offsets read zero
    // Answer one cycle after the strobe, whatever the address
    // Trade-off: a registered read adds a cycle but keeps decode off the output path
    always_comb begin
        // Defaults: zero data, answer follows the strobe
        rdata_next  = 32'h0000_0000;
        rvalid_next = cfg_rd_in;
        if (cfg_rd_in && addr_hit(cfg_addr_in, BCR_DWORD0_OFF)) begin
            // Dword 0 carries the identifier in its upper half
            rdata_next[31:16] = BCR_DEVICE_IDENTIFIER; // RL1
        end else if (cfg_rd_in && addr_hit(cfg_addr_in, BCR_DWORD1_OFF)) begin
            // Only bits 15:0 of dword 1 belong to the command register
            rdata_next[15:0] = command & BCR_COMMAND_WRITE_MASK; // RL2
        end
        // Reset wins over a read in the same cycle
        if (srst_in) begin
            rdata_next  = 32'h0000_0000;
            rvalid_next = 1'b0;
        end
    end

    // Own interrupt messages and forwarded traffic
    // Priority: forwarded traffic, then the withdraw, then the own level
    // At most one message a cycle, so the branches are exclusive
    // A forwarded message only delays an own change by one cycle
    // The sent flag mirrors the far end, so the withdraw goes out once
    always_comb begin
        // Defaults: hold the far-end level, no message
        intr_sent_next = intr_sent_reg;
        msg_valid_next = 1'b0;
        msg_kind_next  = BCR_MSG_NONE;
        // Forwarded messages pass regardless of the disable bit
        if (fwd_msg_valid_in) begin
            msg_valid_next = 1'b1; // RL5
            msg_kind_next  = fwd_msg_kind_in; // RL5
        end else if (interrupt_assertion_disable_out && intr_sent_reg) begin
            // Withdraw a pending assertion when disabled
            msg_valid_next = 1'b1; // RL4
            msg_kind_next  = BCR_MSG_DEASSERT; // RL4
            intr_sent_next = 1'b0; // RL4
        end else if (!interrupt_assertion_disable_out && own_intr_in != intr_sent_reg) begin
            // Follow the own source level while permitted
            // While disabled the level is not tracked; re-enable compares again
            msg_valid_next = 1'b1; // RL3
            msg_kind_next  = own_intr_in ? BCR_MSG_ASSERT : BCR_MSG_DEASSERT; // RL3
            intr_sent_next = own_intr_in; // RL3
        end
        // Reset forces all message state idle
        if (srst_in) begin
            intr_sent_next = 1'b0;
            msg_valid_next = 1'b0;
            msg_kind_next  = BCR_MSG_NONE;
        end
    end

    // SERR generation and parity status gating
    // Device control may raise the message but never the status event
    // Limitation: secondary_err_in is taken in but deliberately unused
    // Each event is a one-cycle pulse taken from a one-cycle input
    always_comb begin
        // Secondary-side errors never raise the message
        serr_next      = primary_err_in && (system_error_message_enable_out || devctl_err_en_in); // RL6 RL7
        serr_stat_next = primary_err_in && system_error_message_enable_out; // RL8
        par_next       = master_parity_err_in && parity_error_report_enable_out; // RL9
        // Reset clears every pending event
        if (srst_in) begin
            serr_next      = 1'b0;
            serr_stat_next = 1'b0;
            par_next       = 1'b0;
        end
    end

    // Read answer registers
    // Nothing but flops here; every decision sits in the comb blocks
    always_ff @(posedge clock_in) begin
        rdata_reg     <= rdata_next;
        rvalid_reg    <= rvalid_next;
    end

    // Interrupt message registers
    always_ff @(posedge clock_in) begin
        intr_sent_reg <= intr_sent_next;
        msg_valid_reg <= msg_valid_next;
        msg_kind_reg  <= msg_kind_next;
    end

    // Error event registers
    always_ff @(posedge clock_in) begin
        serr_reg      <= serr_next;
        serr_stat_reg <= serr_stat_next;
        par_reg       <= par_next;
    end

    // Read answer outputs
    assign cfg_rdata_out         = rdata_reg;
    assign cfg_rvalid_out        = rvalid_reg;
    // Interrupt message outputs
    assign inta_msg_valid_out    = msg_valid_reg;
    assign inta_msg_kind_out     = msg_kind_reg;
    // Error event outputs, all straight from flops
    // Status events feed the primary status register elsewhere in the bridge
    assign serr_msg_out          = serr_reg;
    assign serr_status_set_out   = serr_stat_reg;
    assign parity_status_set_out = par_reg;
endmodule : bcr_bridge_command

//--- bcr_monitor.sv
`timescale 1ns/1ns
module bcr_monitor
    import bcr_pkg::*;
(
    // Clock, reset and configuration access
    input logic        clock_in, srst_in, cfg_rd_in, cfg_wr_in,
    input logic [7:0]  cfg_addr_in,
    input logic [3:0]  cfg_be_in,
    input logic [31:0] cfg_wdata_in, cfg_rdata_out,
    input logic        cfg_rvalid_out,
    // Interrupt messages
    input logic        fwd_msg_valid_in, inta_msg_valid_out,
    input bcr_msg_t    fwd_msg_kind_in, inta_msg_kind_out,
    // Errors and command enables
    input logic        primary_err_in, devctl_err_en_in, master_parity_err_in,
    input logic        serr_msg_out, serr_status_set_out, parity_status_set_out,
    input logic        system_error_message_enable_out, parity_error_report_enable_out,
    input logic        interrupt_assertion_disable_out
);
    // One domain, so one clock and one reset for all
    default clocking @(posedge clock_in); endclocking
    default disable iff (srst_in);
    // Command dword write with the upper lane enabled
    sequence s_cmd_hi_wr;
        cfg_wr_in && cfg_addr_in[7:2] == 6'h01 && cfg_be_in[1];
    endsequence
    a_read_answered: assert property (cfg_rd_in |=> cfg_rvalid_out)
        else $error("read not answered");
    a_ident_value: assert property (cfg_rd_in && cfg_addr_in[7:2] == 6'h00 |=>
        cfg_rdata_out == {BCR_DEVICE_IDENTIFIER, 16'h0000}) else $error("identifier wrong");
    a_reserved_zero: assert property (cfg_rvalid_out |->
        (cfg_rdata_out[15:0] & ~BCR_COMMAND_WRITE_MASK) == 16'h0000) else $error("reserved bit set");
    a_upper_write: assert property (s_cmd_hi_wr |=>
        system_error_message_enable_out == $past(cfg_wdata_in[8])
        && interrupt_assertion_disable_out == $past(cfg_wdata_in[10])) else $error("upper write lost");
    a_parity_hold: assert property (!(cfg_wr_in && cfg_be_in[0]) |=>
        $stable(parity_error_report_enable_out)) else $error("enable changed unwritten");
    a_serr_sent: assert property (primary_err_in && (system_error_message_enable_out
        || devctl_err_en_in) |=> serr_msg_out) else $error("error message missing");
    a_serr_status: assert property (primary_err_in |=>
        serr_status_set_out == $past(system_error_message_enable_out)) else $error("status event wrong");
    a_parity_gate: assert property (master_parity_err_in |=>
        parity_status_set_out == $past(parity_error_report_enable_out)) else $error("parity gate wrong");
    a_no_own_assert: assert property (interrupt_assertion_disable_out && !fwd_msg_valid_in |=>
        !(inta_msg_valid_out && inta_msg_kind_out == BCR_MSG_ASSERT)) else $error("assert while off");
    a_fwd_passes: assert property (fwd_msg_valid_in |=> inta_msg_valid_out
        && inta_msg_kind_out == $past(fwd_msg_kind_in)) else $error("forwarded message lost");
endmodule : bcr_monitor

bind bcr_bridge_command bcr_monitor u_mon (.*);

//--- tb.sv
`timescale 1ns/1ns
module tb;
    import bcr_pkg::*;
    // Design ports, matched by name at the instance
    logic        clock_in, srst_in, cfg_rd_in, cfg_wr_in, own_intr_in, devctl_err_en_in;
    logic        fwd_msg_valid_in, primary_err_in, secondary_err_in, master_parity_err_in;
    logic [7:0]  cfg_addr_in;
    logic [3:0]  cfg_be_in;
    logic [31:0] cfg_wdata_in, cfg_rdata_out, obs;
    logic        cfg_rvalid_out, inta_msg_valid_out, serr_msg_out, serr_status_set_out;
    logic        parity_status_set_out, system_error_message_enable_out;
    logic        parity_error_report_enable_out, interrupt_assertion_disable_out;
    bcr_msg_t    fwd_msg_kind_in, inta_msg_kind_out;
    // Scoreboard notes and bookkeeping
    logic [31:0] q[$];
    logic [31:0] rs = 32'd82392;
    logic [15:0] cur, m;
    logic [2:0]  ens;
    int          n_mismatch = 0;
    int          cmp_count = 0;
    int          k;

    bcr_bridge_command DUT (.*);

    // Command enables as one word, {bit 10, bit 8, bit 6}
    assign ens = {interrupt_assertion_disable_out, system_error_message_enable_out, parity_error_report_enable_out};

    // 25 MHz clock
    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Packed form of an interrupt message result
    function automatic logic [31:0] evm(input bcr_msg_t t);
        return {26'h0, 1'b1, t, 3'b000};
    endfunction : evm

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk

    task automatic final_report;
        $display("compares=%0d mismatches=%0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report

    // One config access; a read notes d as the expected data
    task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        {cfg_wr_in, cfg_rd_in, cfg_addr_in, cfg_be_in, cfg_wdata_in} = {w, !w, a, b, d};
        if (!w) q.push_back(d);
        @(negedge clock_in);
        {cfg_wr_in, cfg_rd_in} = 2'b00;
        repeat (2) @(negedge clock_in);
    endtask : acc

    // Event pulses {fwd, own level, primary, secondary, parity}; h notes e
    task automatic pl(input logic [4:0] s, input bit h, input logic [31:0] e);
        if (h) q.push_back(e);
        {fwd_msg_valid_in, own_intr_in, primary_err_in, secondary_err_in, master_parity_err_in} = s;
        @(negedge clock_in);
        {fwd_msg_valid_in, primary_err_in, secondary_err_in, master_parity_err_in} = 4'h0;
        repeat (3) @(negedge clock_in);
    endtask : pl

    // Oldest note against every result; an extra result meets all ones
    always @(negedge clock_in) begin
        obs = cfg_rvalid_out ? cfg_rdata_out : {26'h0, inta_msg_valid_out, inta_msg_kind_out,
            serr_msg_out, serr_status_set_out, parity_status_set_out};
        if (!srst_in && (cfg_rvalid_out || obs != 32'h0))
            chk(obs, (q.size() > 0) ? q.pop_front() : 32'hffffffff);
    end

    // Watchdog against a hang
    initial begin
        #100000;
        n_mismatch++;
        final_report();
    end

    initial begin
        {cfg_rd_in, cfg_wr_in, cfg_addr_in, cfg_be_in, cfg_wdata_in, devctl_err_en_in} = '0;
        {fwd_msg_valid_in, own_intr_in, primary_err_in, secondary_err_in, master_parity_err_in} = '0;
        fwd_msg_kind_in = BCR_MSG_DEASSERT;
        srst_in = 1'b1;
        repeat (20) @(negedge clock_in);
        srst_in = 1'b0;
        acc(1'b1, 8'h00, 4'hf, 32'hffffffff);
        acc(1'b0, 8'h02, 4'h0, {BCR_DEVICE_IDENTIFIER, 16'h0000});
        acc(1'b0, 8'h04, 4'h0, 32'h0);
        acc(1'b1, 8'h04, 4'hf, 32'hffffffff);
        acc(1'b0, 8'h04, 4'h0, 32'h00000540);
        acc(1'b1, 8'h04, 4'h1, 32'h0);
        acc(1'b0, 8'h04, 4'h0, 32'h00000500);
        acc(1'b1, 8'h08, 4'hf, 32'h0);
        acc(1'b0, 8'h08, 4'h0, 32'h0);
        cur = 16'h0500;
        // Random data and lanes; only lane-enabled writable bits move
        for (k = 0; k < 8; k++) begin
            rs = lfsr(rs);
            m = BCR_COMMAND_WRITE_MASK & {{8{rs[9]}}, {8{rs[8]}}};
            cur = (cur & ~m) | (rs[15:0] & m);
            acc(1'b1, 8'h04, {2'b00, rs[9:8]}, rs);
            acc(1'b0, 8'h04, 4'h0, {16'h0, cur});
            chk({29'h0, ens}, {29'h0, cur[10], cur[8], cur[6]});
        end
        $display("register test done");
        acc(1'b1, 8'h04, 4'h3, 32'h0);
        pl(5'b00100, 1'b0, 32'h0);
        devctl_err_en_in = 1'b1;
        pl(5'b00100, 1'b1, 32'h4);
        devctl_err_en_in = 1'b0;
        acc(1'b1, 8'h04, 4'h3, 32'h0140);
        pl(5'b00100, 1'b1, 32'h6);
        pl(5'b00010, 1'b0, 32'h0);
        pl(5'b00001, 1'b1, 32'h1);
        acc(1'b1, 8'h04, 4'h1, 32'h0);
        pl(5'b00001, 1'b0, 32'h0);
        $display("error test done");
        pl(5'b01000, 1'b1, evm(BCR_MSG_ASSERT));
        q.push_back(evm(BCR_MSG_DEASSERT));
        acc(1'b1, 8'h04, 4'h2, 32'h0400);
        pl(5'b00000, 1'b0, 32'h0);
        pl(5'b01000, 1'b0, 32'h0);
        pl(5'b11000, 1'b1, evm(BCR_MSG_DEASSERT));
        q.push_back(evm(BCR_MSG_ASSERT));
        acc(1'b1, 8'h04, 4'h2, 32'h0);
        pl(5'b00000, 1'b1, evm(BCR_MSG_DEASSERT));
        $display("interrupt test done");
        chk(32'(q.size()), 32'h0);
        final_report();
    end
endmodule : tb
